// ### logic/rsl_fix_note.sv
// Intentionally empty

// ### logic/rsl_pkg.sv
// Package with constants and types of the reset source status logic
package rsl_pkg;
	localparam int              CLK_PERIOD_NS   = 10;
	localparam int              MASTER_CLEAR_PIN_FILTER_NS  = 200;
	localparam int              MASTER_CLEAR_PIN_FILTER_CYC = (MASTER_CLEAR_PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int              RESET_HOLD_CYC  = 4;
	localparam int              ADDR_W          = 12;
	localparam logic [11:0]     RCC_OFFSET      = 12'h000;
	localparam int              BIT_PRIO        = 7;
	localparam int              BIT_SOFT_BROWNOUT_ENABLE      = 6;
	localparam int              BIT_UNUSED      = 5;
	localparam int              BIT_RI          = 4;
	localparam int              BIT_TO          = 3;
	localparam int              BIT_PD          = 2;
	localparam int              BIT_POR         = 1;
	localparam int              BIT_BOR         = 0;
	localparam logic [7:0]      RCC_RESET       = 8'h1C;
	localparam logic [7:0]      RCC_WR_MASK     = 8'hD3;

	typedef enum logic [1:0] {
		BO_OFF  = 2'b00,
		BO_SOFT = 2'b01,
		BO_NOSLP = 2'b10,
		BO_ON   = 2'b11
	} rsl_bocfg_t;

	typedef enum logic [2:0] {
		CAUSE_POR     = 3'b000,
		CAUSE_MASTER_CLEAR_PIN    = 3'b001,
		CAUSE_MASTER_CLEAR_PIN_PM = 3'b010,
		CAUSE_WDT     = 3'b011,
		CAUSE_BOR     = 3'b100,
		CAUSE_RSTI    = 3'b101,
		CAUSE_STKFULL = 3'b110,
		CAUSE_STKUNDR = 3'b111
	} rsl_cause_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} rsl_apb_req_t;
endpackage : rsl_pkg

// ### logic/rsl_reset_status.sv
// Reset source capture, device reset generation and reset cause register
//
// Overview of operation
// - Record one of eight reset causes.
// - Low five bits flag reset causes.
// - Bit 7 enables interrupt priority, resets 0.
// - Bit 6 steers brown-out only in config 01.
// - Bit 6 resets to 1 in software mode.
// - Bit 5 always reads zero.
// - Reset instruction clears bit 4; power-on sets.
// - Bit 3 set by powerup/clear_watchdog_instr/sleep, watchdog clears.
// - Bit 2 set by powerup/clear_watchdog_instr, sleep clears.
// - Power-on clears bit 1; firmware sets.
// - Brown-out clears bit 0; firmware sets.
// - Reset held while master-clear pin low.
// - Filter short pulses on master-clear pin.
// - Never drive master-clear pin low.
// - Disabled master-clear pin is digital input.
// - Internal power-on pulse after supply rise.
// - Brown-out and power-on clear bit 0.
// - Config 10 disables brown-out during sleep.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rsl_reset_status #(
	parameter int FILTER_CYC = rsl_pkg::MASTER_CLEAR_PIN_FILTER_CYC,
	parameter int HOLD_CYC   = rsl_pkg::RESET_HOLD_CYC
) (
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire rsl_pkg::rsl_apb_req_t apbReq,
	output logic                      pready_r,
	output logic [31:0]               prdata_r,
	output logic                      pslverr_r,
	input  wire logic                 masterClearPin,
	input  wire logic                 masterClearPinEnable,
	input  wire logic [1:0]           brownoutConfigField,
	input  wire logic                 brownoutDetect,
	input  wire logic                 powerManaged,
	input  wire logic                 sleeping,
	input  wire logic                 watchdogTimeout,
	input  wire logic                 resetInstr,
	input  wire logic                 stackFull,
	input  wire logic                 stackUnderflow,
	input  wire logic                 clearWatchdogInstr,
	input  wire logic                 sleepInstr,
	output logic                      deviceReset_r,
	output rsl_pkg::rsl_cause_t       resetCause_r,
	output logic                      brownoutEnable_r,
	output logic                      priorityLevelsOn_r,
	output logic                      masterClearDigIn_r,
	output logic                      masterClearPinOut_r,
	output logic                      masterClearPinOe_r
);
	initial begin
		if (FILTER_CYC < 2 || FILTER_CYC > 255 || HOLD_CYC < 1 || HOLD_CYC > 255)
			$error("rsl_reset_status: FILTER_CYC or HOLD_CYC out of range");
	end

	logic                mclrMeta_r, mclrSync_r, borMeta_r, borSync_r;
	logic                porPend_r, porPend_nxt;
	logic [7:0]          lowCnt_r, lowCnt_nxt, holdCnt_r, holdCnt_nxt;
	logic                mclrFilt_r, mclrFilt_nxt, mclrActD_r, borActD_r;
	logic [7:0]          flags_r, flags_nxt;
	logic                devRst_nxt, boEn_nxt;
	rsl_pkg::rsl_cause_t cause_nxt;
	logic                pready_nxt, pslverr_nxt;
	logic [31:0]         prdata_nxt;
	logic                mclrActive, borActive, mclrEvt, borEvt, anyEvt, wrEn, hit;
	logic [7:0]          readVal;

	// Pins are asynchronous; the first stage feeds only the second
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mclrMeta_r <= 1'b1;
			mclrSync_r <= 1'b1;
			borMeta_r  <= 1'b0;
			borSync_r  <= 1'b0;
		end else begin
			mclrMeta_r <= masterClearPin;
			mclrSync_r <= mclrMeta_r;
			borMeta_r  <= brownoutDetect;
			borSync_r  <= borMeta_r;
		end
	end

	always_comb begin
		hit       = apbReq.paddr == rsl_pkg::RCC_OFFSET;
		wrEn      = apbReq.psel & apbReq.penable & pready_r & apbReq.pwrite & hit;
		mclrActive = mclrFilt_r & masterClearPinEnable;
		borActive = borSync_r & brownoutEnable_r;
		mclrEvt   = mclrActive & ~mclrActD_r;
		borEvt    = borActive & ~borActD_r;
		anyEvt    = porPend_r | mclrEvt | borEvt | watchdogTimeout | resetInstr | stackFull | stackUnderflow;
		readVal   = flags_r;
		readVal[rsl_pkg::BIT_UNUSED] = 1'b0;
		readVal[rsl_pkg::BIT_SOFT_BROWNOUT_ENABLE] = flags_r[rsl_pkg::BIT_SOFT_BROWNOUT_ENABLE]
			& (brownoutConfigField == rsl_pkg::BO_SOFT);
	end

	// Power-on pulse: one cycle after the supply reset releases
	always_comb begin
		porPend_nxt = 1'b0;
		// Pin must stay low a whole filter time before it counts
		lowCnt_nxt   = 8'h00;
		mclrFilt_nxt = 1'b0;
		if (!mclrSync_r) begin
			mclrFilt_nxt = mclrFilt_r;
			lowCnt_nxt   = lowCnt_r;
			if (lowCnt_r == 8'(FILTER_CYC - 1))
				mclrFilt_nxt = 1'b1;
			else
				lowCnt_nxt = lowCnt_r + 8'h01;
		end
		holdCnt_nxt = (holdCnt_r != 8'h00) ? holdCnt_r - 8'h01 : 8'h00;
		if (anyEvt)
			holdCnt_nxt = 8'(HOLD_CYC);
		devRst_nxt = porPend_r | mclrActive | borActive | anyEvt | (holdCnt_nxt != 8'h00);
		case (brownoutConfigField)
			rsl_pkg::BO_SOFT:  boEn_nxt = flags_r[rsl_pkg::BIT_SOFT_BROWNOUT_ENABLE];
			rsl_pkg::BO_NOSLP: boEn_nxt = ~sleeping;
			rsl_pkg::BO_ON:    boEn_nxt = 1'b1;
			default:           boEn_nxt = 1'b0;
		endcase
	end

	// Cause priority: power-on first, stack underflow last
	always_comb begin
		cause_nxt = resetCause_r;
		if (porPend_r)
			cause_nxt = rsl_pkg::CAUSE_POR;
		else if (borEvt)
			cause_nxt = rsl_pkg::CAUSE_BOR;
		else if (mclrEvt)
			cause_nxt = powerManaged ? rsl_pkg::CAUSE_MASTER_CLEAR_PIN_PM : rsl_pkg::CAUSE_MASTER_CLEAR_PIN;
		else if (watchdogTimeout)
			cause_nxt = rsl_pkg::CAUSE_WDT;
		else if (resetInstr)
			cause_nxt = rsl_pkg::CAUSE_RSTI;
		else if (stackFull)
			cause_nxt = rsl_pkg::CAUSE_STKFULL;
		else if (stackUnderflow)
			cause_nxt = rsl_pkg::CAUSE_STKUNDR;
	end

	// Software write first; hardware events then override it so none is lost
	always_comb begin
		flags_nxt = flags_r;
		if (wrEn) begin
			flags_nxt = (flags_r & ~rsl_pkg::RCC_WR_MASK) | (apbReq.pwdata[7:0] & rsl_pkg::RCC_WR_MASK);
			if (brownoutConfigField != rsl_pkg::BO_SOFT)
				flags_nxt[rsl_pkg::BIT_SOFT_BROWNOUT_ENABLE] = flags_r[rsl_pkg::BIT_SOFT_BROWNOUT_ENABLE];
		end
		if (clearWatchdogInstr) begin
			flags_nxt[rsl_pkg::BIT_TO] = 1'b1;
			flags_nxt[rsl_pkg::BIT_PD] = 1'b1;
		end
		if (sleepInstr) begin
			flags_nxt[rsl_pkg::BIT_TO] = 1'b1;
			flags_nxt[rsl_pkg::BIT_PD] = 1'b0;
		end
		if (watchdogTimeout)
			flags_nxt[rsl_pkg::BIT_TO] = 1'b0;
		if (resetInstr)
			flags_nxt[rsl_pkg::BIT_RI] = 1'b0;
		if (borEvt)
			flags_nxt[rsl_pkg::BIT_BOR] = 1'b0;
		if (anyEvt)
			flags_nxt[rsl_pkg::BIT_PRIO] = 1'b0;
		if (porPend_r) begin
			flags_nxt = rsl_pkg::RCC_RESET;
			flags_nxt[rsl_pkg::BIT_SOFT_BROWNOUT_ENABLE] = brownoutConfigField == rsl_pkg::BO_SOFT;
		end
	end

	// Zero-wait slave: answer prepared in setup, pready high in access
	always_comb begin
		pready_nxt  = apbReq.psel & ~apbReq.penable;
		pslverr_nxt = pready_nxt & ~hit;
		prdata_nxt  = (pready_nxt & hit & ~apbReq.pwrite) ? {24'h000000, readVal} : 32'h00000000;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			porPend_r           <= 1'b1;
			lowCnt_r            <= 8'h00;
			mclrFilt_r          <= 1'b0;
			mclrActD_r          <= 1'b0;
			borActD_r           <= 1'b0;
			holdCnt_r           <= 8'h00;
			deviceReset_r       <= 1'b1;
			resetCause_r        <= rsl_pkg::CAUSE_POR;
			flags_r             <= rsl_pkg::RCC_RESET;
			brownoutEnable_r    <= 1'b0;
			priorityLevelsOn_r  <= 1'b0;
			masterClearDigIn_r  <= 1'b1;
			masterClearPinOut_r <= 1'b0;
			masterClearPinOe_r  <= 1'b0;
			pready_r            <= 1'b0;
			pslverr_r           <= 1'b0;
			prdata_r            <= 32'h00000000;
		end else begin
			porPend_r           <= porPend_nxt;
			lowCnt_r            <= lowCnt_nxt;
			mclrFilt_r          <= mclrFilt_nxt;
			mclrActD_r          <= mclrActive;
			borActD_r           <= borActive;
			holdCnt_r           <= holdCnt_nxt;
			deviceReset_r       <= devRst_nxt;
			resetCause_r        <= cause_nxt;
			flags_r             <= flags_nxt;
			brownoutEnable_r    <= boEn_nxt;
			priorityLevelsOn_r  <= flags_nxt[rsl_pkg::BIT_PRIO];
			masterClearDigIn_r  <= mclrSync_r;
			masterClearPinOut_r <= 1'b0;
			masterClearPinOe_r  <= 1'b0;
			pready_r            <= pready_nxt;
			pslverr_r           <= pslverr_nxt;
			prdata_r            <= prdata_nxt;
		end
	end

	a_bit5_reads_zero: assert property (@(posedge clock) disable iff (!rst_n)
		pready_r |-> prdata_r[rsl_pkg::BIT_UNUSED] == 1'b0)
		else $error("unimplemented bit read nonzero");
	a_soft_brownout_enable_gated: assert property (@(posedge clock) disable iff (!rst_n)
		pready_r && brownoutConfigField != rsl_pkg::BO_SOFT && $stable(brownoutConfigField)
		|-> prdata_r[rsl_pkg::BIT_SOFT_BROWNOUT_ENABLE] == 1'b0)
		else $error("soft brown-out bit visible outside software mode");
	a_por_clears_flag: assert property (@(posedge clock) disable iff (!rst_n)
		porPend_r |=> !flags_r[rsl_pkg::BIT_POR] && resetCause_r == rsl_pkg::CAUSE_POR && deviceReset_r)
		else $error("power-on did not clear flag");
	a_wdt_clears_to: assert property (@(posedge clock) disable iff (!rst_n)
		watchdogTimeout && !porPend_r |=> !flags_r[rsl_pkg::BIT_TO] && deviceReset_r)
		else $error("watchdog time-out not recorded");
	a_sleep_clears_pd: assert property (@(posedge clock) disable iff (!rst_n)
		sleepInstr && !porPend_r |=> !flags_r[rsl_pkg::BIT_PD] && flags_r[rsl_pkg::BIT_TO] == !$past(watchdogTimeout))
		else $error("sleep did not clear power-down flag");
	a_hw_clear_wins: assert property (@(posedge clock) disable iff (!rst_n)
		wrEn && apbReq.pwdata[rsl_pkg::BIT_RI] && resetInstr && !porPend_r |=> !flags_r[rsl_pkg::BIT_RI])
		else $error("software set beat reset instruction clear");
	// Hold timer is armed by the pin event only, not the low level, so a long low pin releases one cycle after mclrActive falls
	a_master_clear_pin_holds: assert property (@(posedge clock) disable iff (!rst_n)
		mclrActive |=> deviceReset_r)
		else $error("device left reset while master-clear low");
	a_filter_blocks: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(mclrFilt_r) |-> $past(mclrSync_r, 1) == 1'b0 && $past(mclrSync_r, 2) == 1'b0)
		else $error("short pulse passed the filter");
	a_pin_never_driven: assert property (@(posedge clock) disable iff (!rst_n)
		!masterClearPinOe_r)
		else $error("master-clear pin driven");
	a_noslp_bo_off: assert property (@(posedge clock) disable iff (!rst_n)
		brownoutConfigField == rsl_pkg::BO_NOSLP && $stable(brownoutConfigField) |=> brownoutEnable_r == !$past(sleeping))
		else $error("brown-out enable wrong in sleep-off mode");

	// Cause and flag effects of the hardware events
	a_bor_recorded: assert property (@(posedge clock) disable iff (!rst_n)
		borEvt && !porPend_r |=> resetCause_r == rsl_pkg::CAUSE_BOR && !flags_r[rsl_pkg::BIT_BOR] && deviceReset_r)
		else $error("brown-out reset not recorded");
	a_bor_holds: assert property (@(posedge clock) disable iff (!rst_n)
		borActive |=> deviceReset_r)
		else $error("device left reset during brown-out");
	a_master_clear_pin_cause: assert property (@(posedge clock) disable iff (!rst_n)
		mclrEvt && !porPend_r && !borEvt
		|=> resetCause_r == ($past(powerManaged) ? rsl_pkg::CAUSE_MASTER_CLEAR_PIN_PM : rsl_pkg::CAUSE_MASTER_CLEAR_PIN))
		else $error("master-clear cause wrong");
	a_rsti_cause: assert property (@(posedge clock) disable iff (!rst_n)
		resetInstr && !porPend_r && !borEvt && !mclrEvt && !watchdogTimeout
		|=> resetCause_r == rsl_pkg::CAUSE_RSTI && !flags_r[rsl_pkg::BIT_RI])
		else $error("reset instruction cause wrong");
	a_event_clears_prio: assert property (@(posedge clock) disable iff (!rst_n)
		anyEvt |=> !priorityLevelsOn_r && !flags_r[rsl_pkg::BIT_PRIO])
		else $error("priority enable survived a reset");
	a_disabled_pin: assert property (@(posedge clock) disable iff (!rst_n)
		!masterClearPinEnable |-> !mclrEvt)
		else $error("disabled master-clear pin caused a reset");
	a_clear_watchdog_instr_sets: assert property (@(posedge clock) disable iff (!rst_n)
		clearWatchdogInstr && !sleepInstr && !watchdogTimeout && !porPend_r
		|=> flags_r[rsl_pkg::BIT_TO] && flags_r[rsl_pkg::BIT_PD])
		else $error("clear-watchdog did not set flags");

	// Power-on loads the reset pattern
	a_por_sets_ri: assert property (@(posedge clock) disable iff (!rst_n)
		porPend_r |=> flags_r[rsl_pkg::BIT_RI] && flags_r[rsl_pkg::BIT_TO] && flags_r[rsl_pkg::BIT_PD] && !flags_r[rsl_pkg::BIT_BOR])
		else $error("power-on flag pattern wrong");
	a_soft_brownout_enable_reset: assert property (@(posedge clock) disable iff (!rst_n)
		porPend_r |=> flags_r[rsl_pkg::BIT_SOFT_BROWNOUT_ENABLE] == ($past(brownoutConfigField) == rsl_pkg::BO_SOFT))
		else $error("soft brown-out enable reset value wrong");

	// Software access
	a_write_lands: assert property (@(posedge clock) disable iff (!rst_n)
		wrEn && !anyEvt |=> flags_r[rsl_pkg::BIT_POR] == $past(apbReq.pwdata[rsl_pkg::BIT_POR])
		&& flags_r[rsl_pkg::BIT_BOR] == $past(apbReq.pwdata[rsl_pkg::BIT_BOR]))
		else $error("software write did not land");
	a_ro_bits_kept: assert property (@(posedge clock) disable iff (!rst_n)
		wrEn && !anyEvt && !clearWatchdogInstr && !sleepInstr
		|=> $stable(flags_r[rsl_pkg::BIT_TO]) && $stable(flags_r[rsl_pkg::BIT_PD]))
		else $error("read-only flag changed by write");
	a_unmapped_err: assert property (@(posedge clock) disable iff (!rst_n)
		pready_r |-> pslverr_r == ($past(apbReq.paddr) != rsl_pkg::RCC_OFFSET))
		else $error("slave error flag wrong");

	c_master_clear_pin_reset: cover property (@(posedge clock) disable iff (!rst_n) mclrEvt ##1 resetCause_r == rsl_pkg::CAUSE_MASTER_CLEAR_PIN);
	c_bor_reset: cover property (@(posedge clock) disable iff (!rst_n) borEvt);
	c_sw_write: cover property (@(posedge clock) disable iff (!rst_n) wrEn);
	c_wdt_reset: cover property (@(posedge clock) disable iff (!rst_n) watchdogTimeout ##1 deviceReset_r);
	c_hw_beats_sw: cover property (@(posedge clock) disable iff (!rst_n) wrEn && resetInstr);
endmodule : rsl_reset_status
`default_nettype wire

// ### verif/rsl_master_clear_pin_model.sv
// External reset circuit model that drives the master-clear pin
`timescale 1ns/1ps
`default_nettype none
module rsl_master_clear_pin_model (
	input  wire logic       clock,
	input  wire logic       go,
	input  wire logic [7:0] lowCyc,
	output logic            pin
);
	int n = 0;
	// Pull-up holds the pin high between pulses
	always @(posedge clock) begin
		if (go) n <= int'(lowCyc);
		else if (n > 0) n <= n - 1;
	end
	assign pin = (n == 0);
endmodule : rsl_master_clear_pin_model
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench of the reset source status logic
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                  clock = 0;
	logic                  rst_n = 0;
	rsl_pkg::rsl_apb_req_t apbReq = '0;
	logic [31:0]           prdata, d, r;
	logic [1:0]            cfg = 2'b01;
	logic [3:0]            ev = '0;
	logic [7:0]            lowCyc = '0, expReg;
	logic [2:0]            cause, cs [4] = '{3'd3, 3'd5, 3'd6, 3'd7};
	logic                  pready, pslverr, pin, e, devRst, prio, bEn, digIn, pOut, pOe;
	logic                  go = 0, mcEn = 1, bod = 0, pm = 0, slp = 0, clrw = 0, slpi = 0, oeBad = 0;
	int                    err_count = 0, check_count = 0;
	always #5 clock = ~clock;
	rsl_master_clear_pin_model PM (.clock(clock), .go(go), .lowCyc(lowCyc), .pin(pin));
	rsl_reset_status #(.FILTER_CYC(3), .HOLD_CYC(4)) DUT (.clock(clock), .rst_n(rst_n), .apbReq(apbReq),
		.pready_r(pready), .prdata_r(prdata), .pslverr_r(pslverr), .masterClearPin(pin),
		.masterClearPinEnable(mcEn), .brownoutConfigField(cfg), .brownoutDetect(bod), .powerManaged(pm),
		.sleeping(slp), .watchdogTimeout(ev[0]), .resetInstr(ev[1]), .stackFull(ev[2]),
		.stackUnderflow(ev[3]), .clearWatchdogInstr(clrw), .sleepInstr(slpi), .deviceReset_r(devRst),
		.resetCause_r(cause), .brownoutEnable_r(bEn), .priorityLevelsOn_r(prio),
		.masterClearDigIn_r(digIn), .masterClearPinOut_r(pOut), .masterClearPinOe_r(pOe));
	always @(negedge clock) if (pOe !== 1'b0 || pOut !== 1'b0) oeBad <= 1;
	task automatic cmp(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask : cmp
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	// Request stands until pready is sampled high at a rising edge; data taken there
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		apbReq <= '{1'b1, 1'b0, w, a, wd};
		@(posedge clock);
		apbReq.penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clock);
			n++;
		end
		r = prdata;
		e = pslverr;
		cmp(pready, 1);
		apbReq <= '0;
		@(posedge clock);
	endtask : apb
	task automatic rd;
		apb(0, 12'h000, 0);
		cmp(r, {24'h0, expReg[7], expReg[6] & (cfg == 2'b01), 1'b0, expReg[4:0]});
		cmp(e, 0);
		cmp(prio, expReg[7]);
	endtask : rd
	task automatic wr(input logic [7:0] v);
		logic [7:0] m;
		m = (cfg == 2'b01) ? 8'hD3 : 8'h93;
		apb(1, 12'h000, {24'h0, v});
		expReg = (expReg & ~m) | (v & m);
	endtask : wr
	task automatic waitRst(input logic [2:0] c);
		int n;
		n = 0;
		while (devRst !== 1'b1 && n < 60) begin @(negedge clock); n++; end
		cmp(devRst, 1);
		cmp(cause, c);
		n = 0;
		while (devRst !== 1'b0 && n < 60) begin @(negedge clock); n++; end
		cmp(devRst, 0);
		cmp(pin, 1);
		@(posedge clock);
	endtask : waitRst
	task automatic noRst;
		repeat (30) begin @(negedge clock); cmp(devRst, 0); end
		@(posedge clock);
	endtask : noRst
	task automatic mcPulse(input logic [7:0] k);
		lowCyc <= k;
		go <= 1;
		@(posedge clock);
		go <= 0;
	endtask : mcPulse
	initial begin
		d = $urandom(94);
		expReg = 8'h5C;
		repeat (2) @(posedge clock);
		rst_n <= 1;
		waitRst(3'd0);
		rd();
		cmp(bEn, 1);
		repeat (3) begin d = $urandom; wr(d[7:0]); rd(); end
		apb(0, 12'h004, 0);
		cmp({e, r}, {1'b1, 32'h0});
		apb(1, 12'h008, '1);
		rd();
		wr(8'hFF);
		slpi <= 1;
		@(posedge clock);
		slpi <= 0;
		expReg[3:2] = 2'b10;
		rd();
		clrw <= 1;
		@(posedge clock);
		clrw <= 0;
		expReg[3:2] = 2'b11;
		rd();
		for (int k = 0; k < 4; k++) begin
			wr(8'hFF);
			ev <= 4'h1 << k;
			@(posedge clock);
			ev <= '0;
			waitRst(cs[k]);
			expReg[7] = 0;
			if (k == 0) expReg[3] = 0;
			if (k == 1) expReg[4] = 0;
			rd();
		end
		fork
			wr(8'hFF);
			begin @(posedge clock); ev <= 4'h2; @(posedge clock); ev <= '0; end
		join
		waitRst(3'd5);
		expReg[7] = 0;
		expReg[4] = 0;
		rd();
		mcPulse(8'd2);
		noRst();
		for (int m = 0; m < 2; m++) begin
			wr(8'hFF);
			pm <= m[0];
			mcPulse(8'd30);
			waitRst(3'd1 + 3'(m));
			expReg[7] = 0;
			rd();
		end
		mcEn <= 0;
		mcPulse(8'd20);
		repeat (6) @(negedge clock);
		cmp(digIn, 0);
		noRst();
		mcEn <= 1;
		wr(8'hFF);
		bod <= 1;
		repeat (8) @(posedge clock);
		bod <= 0;
		waitRst(3'd4);
		expReg[7] = 0;
		expReg[0] = 0;
		rd();
		cfg <= 2'b00;
		@(posedge clock);
		rd();
		cfg <= 2'b10;
		slp <= 1;
		repeat (3) @(negedge clock);
		cmp(bEn, 0);
		@(posedge clock);
		slp <= 0;
		repeat (3) @(negedge clock);
		cmp(bEn, 1);
		rst_n <= 0;
		repeat (2) @(posedge clock);
		rst_n <= 1;
		expReg = 8'h1C;
		waitRst(3'd0);
		rd();
		cmp(oeBad, 0);
		report_and_stop();
	end
	initial begin
		#200000;
		err_count++;
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
